// file: verilog/edsc_cfg.svh
/*
  register offsets, field positions and feature codes of the external debug
  sample and control block.
  assumes: included by the top module of this block.
*/
// Notes on behaviour
// (R1) halted or prohibited: sample reads all-ones sentinel
// (R2) first read after reset may give sentinel
// (R3) sample undefined without retirement since last event
// (R4) sentinel or undefined read spoils companion samples
// (R5) good read returns address, loads companion samples
// (R6) locked memory-mapped read skips companion capture
// (R7) sample register changes on cold reset only
// (R8) status/control flags reset on cold reset only
// (R9) interrupt controller field: 0000 none, 0001 v3
// (R10) vector, float fields: 0000 present, 1111 absent
// (R11) level 3 and 2 state fields read 0000
// (R12) level 1 and 0 state fields read 0000
// (R13) processor feature halves at D20 and D24
// (R14) debug feature halves at D28 and D2C
// (R15) bit 4 write one requests imprecise halt
// (R16) debugger sets halt request only when pending
// (R17) halt request ignored if absent or disabled
// (R18) bit 3 write one clears pipeline advance flag
// (R19) bit 2 clears sticky errors, overrun in halt
// (R20) pipeline advance flag set on retirement, sticky
// (R21) error flag set by halt exception or overrun
// (R22) virtual context bit 30 marks level 2 sample
// (R23) reserved bits read zero, writes ignored
`ifndef EDSC_CFG_SVH
`define EDSC_CFG_SVH
`define EDSC_OFS_STATUS_CTRL 12'h088
`define EDSC_OFS_RESERVE_CTRL 12'h090
`define EDSC_OFS_PC_SAMPLE 12'h0A0
`define EDSC_OFS_CTX_SAMPLE 12'h0A4
`define EDSC_OFS_VCTX_SAMPLE 12'h0A8
`define EDSC_OFS_PFR_LO 12'hD20
`define EDSC_OFS_PFR_HI 12'hD24
`define EDSC_OFS_DFR_LO 12'hD28
`define EDSC_OFS_DFR_HI 12'hD2C
`define EDSC_BIT_HALT_REQ 4
`define EDSC_BIT_CLR_PIPE 3
`define EDSC_BIT_CLR_STICKY 2
`define EDSC_BIT_INSTR_OVR 28
`define EDSC_BIT_RX_OVR 27
`define EDSC_BIT_TX_UND 26
`define EDSC_BIT_PIPE_ADV 25
`define EDSC_BIT_ERR 6
`define EDSC_BIT_VCTX_NS 31
`define EDSC_BIT_VCTX_EL2 30
`define EDSC_SENTINEL 32'hFFFFFFFF
`define EDSC_FEAT_IMPL 4'h0
`define EDSC_FEAT_ABSENT 4'hF
`define EDSC_INTC_NONE 4'h0
`define EDSC_INTC_V3 4'h1
`define EDSC_EL_A32_ONLY 4'h0
`endif

// file: verilog/edsc_pkg.sv
/*
  types shared by the external debug sample and control block.
  assumes: compiled before the top module.
*/
package edsc_pkg;
  // outcome of a sample read
  typedef enum logic [1:0] {EDSC_RD_GOOD, EDSC_RD_SENT, EDSC_RD_UNDEF} edsc_rd_t;
endpackage : edsc_pkg

// file: verilog/edsc_top.sv
/*
  external debug sample and control registers: pc sample with companion
  context samples, feature id halves, reserve control and sticky flags.
  assumes: one 20 MHz clock; cold reset is rst_n; warm and debug resets are
  not wired here at all, so they cannot touch these registers; register port
  is a simple one-cycle strobe port from the debug access logic.
*/
`timescale 1ns/1ps
`include "edsc_cfg.svh"
module edsc_top
  import edsc_pkg::*;
#(
  parameter bit HALT_REQ_IMPL = 1'b1, // imprecise halt request built in
  parameter bit EL2_IMPL = 1'b1, // level 2 present
  parameter bit INTC_IF_IMPL = 1'b1, // system interface to cpu if v3
  parameter bit VEC_IMPL = 1'b1, // vector extension present
  parameter bit FLT_IMPL = 1'b1, // floating point present
  parameter logic [31:0] DFR_LO_VAL = 32'h0000_0000, // debug feature low half
  parameter bit FIRST_READ_SENT = 1'b0 // sentinel on first read after reset
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_mmap, // access came over memory-mapped path
  input wire logic [11:0] reg_addr, // byte offset
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata, // valid the cycle after reg_rd
  output logic reg_rvalid,
  input wire logic software_lock_flag, // memory-mapped lock engaged
  input wire logic pe_halted, // in debug state
  input wire logic pe_in_reset, // in reset state
  input wire logic profiling_prohibited,
  input wire logic instr_retired, // pulse: one or more retired
  input wire logic [31:0] cur_pc, // address of retiring instruction
  input wire logic [31:0] cur_ctx_id,
  input wire logic [7:0] cur_vmid,
  input wire logic cur_at_el2,
  input wire logic halt_exception, // pulse: exception taken in debug state
  input wire logic tx_underrun_ev, // pulse
  input wire logic rx_overrun_ev, // pulse
  input wire logic instr_overrun_ev, // pulse
  input wire logic invasive_debug_allowed, // raw authentication level
  input wire logic hyp_invasive_debug_allowed, // raw authentication level
  output logic imprecise_halt_request, // one-cycle pulse to halt logic
  output logic pipeline_advanced_flag,
  output logic tx_underrun_flag,
  output logic receive_overrun_flag,
  output logic instr_transfer_overrun,
  output logic cumul_error_flag
);
  // sticky flags and sample state
  logic [31:0] pc_q, pc_d; // latest retired address
  logic [31:0] ctx_q, ctx_d; // context at latest retirement
  logic [7:0] vmid_q, vmid_d;
  logic el2_q, el2_d;
  logic fresh_q, fresh_d; // retired since last sample event
  logic first_q, first_d; // no sample read since reset
  logic [31:0] pc_smp_q, pc_smp_d; // companion captures
  logic [31:0] ctx_smp_q, ctx_smp_d;
  logic [31:0] vctx_smp_q, vctx_smp_d;
  logic [31:0] rdata_d;
  logic rvalid_d;
  logic halt_d, pipe_d, tx_und_d, rx_ovr_d, instr_ovr_d, err_d;
  logic [1:0] inv_sync_q, hyp_sync_q; // two-flop synchronisers
  logic inv_ok, hyp_ok;
  logic wr_rcr, rd_pcs, clr_pipe, clr_sticky;
  edsc_rd_t rd_kind;

  // feature value built from parameters; one function serves both extensions
  function automatic logic [3:0] edsc_feat(input logic impl);
    edsc_feat = impl ? `EDSC_FEAT_IMPL : `EDSC_FEAT_ABSENT;
  endfunction : edsc_feat

  logic [31:0] pfr_lo;
  assign pfr_lo = {4'h0,
    (INTC_IF_IMPL ? `EDSC_INTC_V3 : `EDSC_INTC_NONE), // R9
    edsc_feat(VEC_IMPL), edsc_feat(FLT_IMPL), // R10
    `EDSC_EL_A32_ONLY, `EDSC_EL_A32_ONLY, // R11
    `EDSC_EL_A32_ONLY, `EDSC_EL_A32_ONLY}; // R12

  // authentication levels come from outside the clock domain
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      inv_sync_q <= 2'h0;
      hyp_sync_q <= 2'h0;
    end
    else
    begin
      inv_sync_q <= {inv_sync_q[0], invasive_debug_allowed};
      hyp_sync_q <= {hyp_sync_q[0], hyp_invasive_debug_allowed};
    end
  end
  assign inv_ok = inv_sync_q[1];
  assign hyp_ok = hyp_sync_q[1] || !EL2_IMPL;

  // decode of strobes
  assign wr_rcr = reg_wr && (reg_addr == `EDSC_OFS_RESERVE_CTRL);
  assign rd_pcs = reg_rd && (reg_addr == `EDSC_OFS_PC_SAMPLE);
  assign clr_pipe = wr_rcr && reg_wdata[`EDSC_BIT_CLR_PIPE]; // R18
  assign clr_sticky = wr_rcr && reg_wdata[`EDSC_BIT_CLR_STICKY]; // R19

  // classify a sample read; halted or prohibited sentinel beats undefined, undefined beats first-read sentinel
  always_comb
  begin
    if (pe_halted || profiling_prohibited)
      rd_kind = EDSC_RD_SENT; // R1
    else if (pe_in_reset || !fresh_q)
      rd_kind = EDSC_RD_UNDEF; // R3
    else if (first_q && FIRST_READ_SENT)
      rd_kind = EDSC_RD_SENT; // R2
    else
      rd_kind = EDSC_RD_GOOD;
  end

  // next values of sample state and sample captures
  always_comb
  begin
    pc_d = pc_q;
    ctx_d = ctx_q;
    vmid_d = vmid_q;
    el2_d = el2_q;
    fresh_d = fresh_q;
    first_d = first_q;
    pc_smp_d = pc_smp_q;
    ctx_smp_d = ctx_smp_q;
    vctx_smp_d = vctx_smp_q;
    // track the most recent retirement while running
    if (instr_retired && !pe_halted && !pe_in_reset)
    begin
      pc_d = cur_pc;
      ctx_d = cur_ctx_id;
      vmid_d = cur_vmid;
      el2_d = cur_at_el2 && EL2_IMPL;
    end
    // leaving states that spoil the sample: need a new retirement
    if (pe_in_reset || pe_halted || profiling_prohibited)
      fresh_d = 1'b0; // R3
    else if (instr_retired)
      fresh_d = 1'b1;
    if (rd_pcs)
    begin
      first_d = 1'b0;
      fresh_d = instr_retired && !pe_halted && !pe_in_reset; // R3
      pc_smp_d = (rd_kind == EDSC_RD_SENT) ? `EDSC_SENTINEL : pc_q; // R1
      // locked memory-mapped read leaves companions alone
      if (!(reg_mmap && software_lock_flag)) // R6
      begin
        if (rd_kind == EDSC_RD_GOOD)
        begin
          ctx_smp_d = ctx_q; // R5
          vctx_smp_d = 32'h0;
          vctx_smp_d[`EDSC_BIT_VCTX_NS] = 1'b1;
          vctx_smp_d[`EDSC_BIT_VCTX_EL2] = el2_q; // R22
          vctx_smp_d[7:0] = el2_q ? 8'h00 : vmid_q;
        end
        else
        begin
          // undefined contents: chosen as zero, cheapest to build
          ctx_smp_d = 32'h0; // R4
          vctx_smp_d = 32'h0; // R4
        end
      end
    end
  end

  // sticky status flags; a set in the clearing cycle wins
  always_comb
  begin
    pipe_d = instr_retired || (pipeline_advanced_flag && !clr_pipe); // R20
    tx_und_d = tx_underrun_ev || (tx_underrun_flag && !clr_sticky);
    rx_ovr_d = rx_overrun_ev || (receive_overrun_flag && !clr_sticky);
    // overrun flag only clears while halted; running it keeps its value
    instr_ovr_d = instr_overrun_ev
                  || (instr_transfer_overrun && !(clr_sticky && pe_halted)); // R19
    err_d = halt_exception || tx_underrun_ev || rx_overrun_ev || instr_overrun_ev
            || (cumul_error_flag && !clr_sticky); // R21
    // halt request only when built in and allowed
    halt_d = wr_rcr && reg_wdata[`EDSC_BIT_HALT_REQ] && HALT_REQ_IMPL
             && inv_ok && hyp_ok; // R15 R17
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    rvalid_d = reg_rd;
    rdata_d = 32'h0; // R23
    if (reg_rd)
    begin
      unique case (reg_addr)
        `EDSC_OFS_PC_SAMPLE: rdata_d = pc_smp_d; // R5
        `EDSC_OFS_CTX_SAMPLE: rdata_d = ctx_smp_q;
        `EDSC_OFS_VCTX_SAMPLE: rdata_d = vctx_smp_q;
        `EDSC_OFS_STATUS_CTRL: rdata_d = {3'h0, instr_transfer_overrun, receive_overrun_flag,
          tx_underrun_flag, pipeline_advanced_flag, 18'h0, cumul_error_flag, 6'h0};
        `EDSC_OFS_PFR_LO: rdata_d = pfr_lo; // R13
        `EDSC_OFS_PFR_HI: rdata_d = 32'h0; // R13
        `EDSC_OFS_DFR_LO: rdata_d = DFR_LO_VAL; // R14
        `EDSC_OFS_DFR_HI: rdata_d = 32'h0; // R14
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // registers; only cold reset (rst_n) clears the flags
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pc_q <= 32'h0; // R7
      ctx_q <= 32'h0;
      vmid_q <= 8'h0;
      el2_q <= 1'b0;
      fresh_q <= 1'b0;
      first_q <= 1'b1;
      pc_smp_q <= 32'h0; // R7
      ctx_smp_q <= 32'h0;
      vctx_smp_q <= 32'h0;
      reg_rdata <= 32'h0;
      reg_rvalid <= 1'b0;
      imprecise_halt_request <= 1'b0;
      pipeline_advanced_flag <= 1'b0; // R8
      tx_underrun_flag <= 1'b0;
      receive_overrun_flag <= 1'b0;
      instr_transfer_overrun <= 1'b0;
      cumul_error_flag <= 1'b0;
    end
    else
    begin
      pc_q <= pc_d;
      ctx_q <= ctx_d;
      vmid_q <= vmid_d;
      el2_q <= el2_d;
      fresh_q <= fresh_d;
      first_q <= first_d;
      pc_smp_q <= pc_smp_d;
      ctx_smp_q <= ctx_smp_d;
      vctx_smp_q <= vctx_smp_d;
      reg_rdata <= rdata_d;
      reg_rvalid <= rvalid_d;
      imprecise_halt_request <= halt_d;
      pipeline_advanced_flag <= pipe_d;
      tx_underrun_flag <= tx_und_d;
      receive_overrun_flag <= rx_ovr_d;
      instr_transfer_overrun <= instr_ovr_d;
      cumul_error_flag <= err_d;
    end
  end

  // sentinel when halted or prohibited
  a_sentinel_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `EDSC_OFS_PC_SAMPLE && (pe_halted || profiling_prohibited)
    |=> reg_rdata == `EDSC_SENTINEL) // R1
    else $error("sample read not sentinel while halted");
  // locked memory-mapped read keeps companions
  a_lock_keeps_ctx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_pcs && reg_mmap && software_lock_flag |=> $stable(ctx_smp_q) && $stable(vctx_smp_q)) // R6
    else $error("locked read changed companion samples");
  // good read loads context
  a_good_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_pcs && rd_kind == EDSC_RD_GOOD && !(reg_mmap && software_lock_flag)
    |=> ctx_smp_q == $past(ctx_q) && reg_rdata == $past(pc_q)) // R5
    else $error("good read did not capture sample");
  // pipeline flag cleared by write, unless retiring
  a_pipe_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_pipe && !instr_retired |=> !pipeline_advanced_flag) // R18
    else $error("pipeline advance flag not cleared");
  a_pipe_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    instr_retired |=> pipeline_advanced_flag ##1 (pipeline_advanced_flag || $past(clr_pipe))) // R20
    else $error("pipeline advance flag not set");
  // sticky clear leaves overrun alone while running
  a_ito_running: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr_sticky && !pe_halted && instr_transfer_overrun |=> instr_transfer_overrun) // R19
    else $error("instruction overrun cleared while running");
  a_err_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    halt_exception || rx_overrun_ev
    |=> cumul_error_flag && $past(halt_exception || rx_overrun_ev)) // R21
    else $error("error flag not set");
  // halt request blocked without authentication
  a_halt_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    imprecise_halt_request |-> $past(inv_ok) && $past(wr_rcr)) // R17
    else $error("halt request while debug disabled");
  a_pfr_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `EDSC_OFS_PFR_LO |=> reg_rdata[15:0] == 16'h0) // R12
    else $error("state fields not zero");
endmodule : edsc_top

// file: test/edsc_dbg_model.sv
/*
  external debugger model: register reads and writes on the strobe port.
  assumes: one clock; the bench calls rd and wr only after reset release.
*/
`timescale 1ns/1ps
module edsc_dbg_model (
  input wire logic sys_clk,
  input wire logic halt_pending, // external debug request already pending
  output logic reg_rd,
  output logic reg_wr,
  output logic reg_mmap,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle bus at time zero
  initial
  begin
    {reg_rd, reg_wr, reg_mmap, reg_addr, reg_wdata} = '0;
  end

  // read: strobe one cycle, take data from the answer cycle
  task automatic rd(input logic [11:0] a, input logic mm, output logic [31:0] d);
    @(posedge sys_clk);
    #1;
    {reg_rd, reg_mmap, reg_addr} = {1'b1, mm, a};
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a; // released address shows no stale value
    d = reg_rvalid ? reg_rdata : 32'hXXXX_XXXX;
  endtask : rd

  // write: halt request bit only sent while a request is pending
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    #1;
    {reg_wr, reg_mmap, reg_addr} = {1'b1, 1'b0, a};
    reg_wdata = halt_pending ? v : (v & 32'hFFFF_FFEF);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata; // released data is not held
  endtask : wr
endmodule : edsc_dbg_model

// file: test/tb.sv
/*
  self-checking bench of the external debug sample and control block.
  assumes: design and debugger model compiled first; 20 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  localparam bit INTC = 1'b1; // cpu interface present
  localparam bit VEC = 1'b1;
  localparam bit FLT = 1'b0; // float absent, so its field shows all ones
  localparam logic [31:0] DFR_LO = 32'h0021_3110; // arbitrary feature word
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_rd, reg_wr, reg_mmap, reg_rvalid, halt_pending;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cur_pc, cur_ctx_id;
  logic [7:0] cur_vmid;
  logic cur_at_el2, software_lock_flag, pe_halted, pe_in_reset, profiling_prohibited;
  logic invasive_debug_allowed, hyp_invasive_debug_allowed, imprecise_halt_request;
  logic [4:0] ev; // retire, halt exception, tx, rx, instr overrun
  logic [4:0] flags; // pipe, tx, rx, instr overrun, error
  int bad_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000_005B;

  always #25 sys_clk = ~sys_clk;

  edsc_top #(.INTC_IF_IMPL(INTC), .VEC_IMPL(VEC), .FLT_IMPL(FLT), .DFR_LO_VAL(DFR_LO))
  i_edsc_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_mmap(reg_mmap), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .software_lock_flag(software_lock_flag), .pe_halted(pe_halted),
    .pe_in_reset(pe_in_reset), .profiling_prohibited(profiling_prohibited),
    .instr_retired(ev[4]), .cur_pc(cur_pc), .cur_ctx_id(cur_ctx_id),
    .cur_vmid(cur_vmid), .cur_at_el2(cur_at_el2), .halt_exception(ev[3]),
    .tx_underrun_ev(ev[2]), .rx_overrun_ev(ev[1]), .instr_overrun_ev(ev[0]),
    .invasive_debug_allowed(invasive_debug_allowed),
    .hyp_invasive_debug_allowed(hyp_invasive_debug_allowed),
    .imprecise_halt_request(imprecise_halt_request),
    .pipeline_advanced_flag(flags[4]), .tx_underrun_flag(flags[3]),
    .receive_overrun_flag(flags[2]), .instr_transfer_overrun(flags[1]),
    .cumul_error_flag(flags[0]));

  edsc_dbg_model i_edsc_dbg_model (.sys_clk(sys_clk), .halt_pending(halt_pending),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_mmap(reg_mmap), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected feature words; anything else in the hole reads zero
  function automatic logic [31:0] exp_feat(input logic [11:0] a);
    if (a == 12'hD20)
      return {4'h0, 3'b000, INTC, {4{~VEC}}, {4{~FLT}}, 16'h0000};
    return (a == 12'hD28) ? DFR_LO : 32'h0000_0000;
  endfunction : exp_feat

  // virtual context sample: top bit fixed, level 2 mark, vmid hidden at level 2
  function automatic logic [31:0] exp_vctx(input logic at_el2, input logic [7:0] vm);
    return {1'b1, at_el2, 22'h000000, at_el2 ? 8'h00 : vm};
  endfunction : exp_vctx

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle event pulse, flags land at the same edge
  task automatic step(input logic [4:0] v);
    @(posedge sys_clk);
    #1;
    ev = v;
    @(posedge sys_clk);
    #1;
    ev = 5'h00;
  endtask : step

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    #(50 * 4000);
    bad_count++;
    summarize();
  end

  initial
  begin : main
    logic [31:0] d, ctx1;
    logic [11:0] fa [5];
    fa = '{12'hD20, 12'hD24, 12'hD28, 12'hD2C, 12'h0FC};
    {ev, software_lock_flag, pe_halted, pe_in_reset, profiling_prohibited} = '0;
    {cur_pc, cur_ctx_id, cur_vmid, cur_at_el2, halt_pending} = '0;
    {invasive_debug_allowed, hyp_invasive_debug_allowed} = 2'b11;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    // feature halves and an unmapped hole
    foreach (fa[i])
    begin
      i_edsc_dbg_model.rd(fa[i], 1'b0, d);
      chk("feature", exp_feat(fa[i]), d);
    end
    // random samples, both translation levels
    for (int i = 0; i < 6; i++)
    begin
      {cur_pc, cur_ctx_id} = {rnd(), rnd()};
      d = rnd();
      {cur_vmid, cur_at_el2} = d[31:23];
      step(5'h10);
      i_edsc_dbg_model.rd(12'h0A0, 1'b0, d);
      chk("pc sample", cur_pc, d);
      i_edsc_dbg_model.rd(12'h0A4, 1'b0, d);
      chk("ctx sample", cur_ctx_id, d);
      i_edsc_dbg_model.rd(12'h0A8, 1'b0, d);
      chk("vctx sample", exp_vctx(cur_at_el2, cur_vmid), d);
    end
    // read with no retirement since the last one spoils the companion
    i_edsc_dbg_model.rd(12'h0A0, 1'b0, d);
    i_edsc_dbg_model.rd(12'h0A4, 1'b0, d);
    chk("stale ctx", 32'h0000_0000, d);
    // halted, then profiling prohibited: sentinel and spoiled companion
    for (int k = 0; k < 2; k++)
    begin
      {pe_halted, profiling_prohibited} = (k == 0) ? 2'b10 : 2'b01;
      step(5'h10);
      i_edsc_dbg_model.rd(12'h0A0, 1'b0, d);
      chk("sentinel", 32'hFFFF_FFFF, d);
      i_edsc_dbg_model.rd(12'h0A4, 1'b0, d);
      chk("spoiled ctx", 32'h0000_0000, d);
    end
    {pe_halted, profiling_prohibited} = 2'b00;
    // locked memory-mapped read must not recapture
    ctx1 = cur_ctx_id;
    step(5'h10);
    i_edsc_dbg_model.rd(12'h0A0, 1'b0, d);
    cur_ctx_id = rnd();
    step(5'h10);
    software_lock_flag = 1'b1;
    i_edsc_dbg_model.rd(12'h0A0, 1'b1, d);
    software_lock_flag = 1'b0;
    i_edsc_dbg_model.rd(12'h0A4, 1'b0, d);
    chk("locked ctx", ctx1, d);
    // sticky flags set, cleared by reserve control
    step(5'h10);
    chk("flags", 32'h10, {27'h0, flags});
    i_edsc_dbg_model.wr(12'h090, 32'h0000_0000);
    chk("flags", 32'h10, {27'h0, flags});
    i_edsc_dbg_model.wr(12'h090, 32'h0000_0008);
    chk("flags", 32'h00, {27'h0, flags});
    step(5'h07);
    chk("flags", 32'h0F, {27'h0, flags});
    // status word: overrun 28, receive 27, transmit 26, error 6
    i_edsc_dbg_model.rd(12'h088, 1'b0, d);
    chk("status", 32'h1C00_0040, d);
    i_edsc_dbg_model.wr(12'h090, 32'h0000_0004);
    chk("flags", 32'h02, {27'h0, flags});
    pe_halted = 1'b1;
    i_edsc_dbg_model.wr(12'h090, 32'h0000_0004);
    chk("flags", 32'h00, {27'h0, flags});
    step(5'h08);
    chk("flags", 32'h01, {27'h0, flags});
    pe_halted = 1'b0;
    // cold reset in mid-run clears the flags
    step(5'h10);
    rst_n = 1'b0;
    @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk("flags", 32'h00, {27'h0, flags});
    // halt request under every authentication pair
    halt_pending = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      {invasive_debug_allowed, hyp_invasive_debug_allowed} = k[1:0];
      repeat (3) @(posedge sys_clk);
      i_edsc_dbg_model.wr(12'h090, 32'h0000_0010);
      chk("halt req", {31'h0, k == 3}, {31'h0, imprecise_halt_request});
      @(posedge sys_clk);
      #1;
      chk("halt req", 32'h0, {31'h0, imprecise_halt_request});
    end
    i_edsc_dbg_model.wr(12'h094, 32'hFFFF_FFFF);
    chk("halt req", 32'h0, {31'h0, imprecise_halt_request});
    summarize();
  end
endmodule : tb
